//--- include/swt_pkg.sv
// Package for the wake supervision timer and LIN transceiver control block
package swt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SWT_WAKE_CFG_ADDR = 8'h1C;
    localparam logic [7:0] SWT_LIN_CTRL_ADDR = 8'h1D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SWT_SUP_DIS_BIT = 7;
    localparam int SWT_WIN_SEL_HI = 6;
    localparam int SWT_WIN_SEL_LO = 3;
    localparam int SWT_LIN_MODE_HI = 7;
    localparam int SWT_LIN_MODE_LO = 6;
    localparam int SWT_DTO_DIS_BIT = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic SWT_SUP_DIS_RST = 1'h0;
    localparam logic [3:0] SWT_WIN_SEL_RST = 4'h6;
    localparam logic [1:0] SWT_LIN_MODE_RST = 2'h0;
    localparam logic SWT_DTO_DIS_RST = 1'h0;

    // ------------------------------------------------------------
    // Transceiver modes
    // ------------------------------------------------------------
    localparam logic [1:0] SWT_MODE_STANDBY = 2'h0;
    localparam logic [1:0] SWT_MODE_SLEEP = 2'h1;
    localparam logic [1:0] SWT_MODE_NORMAL = 2'h2;
    localparam logic [1:0] SWT_MODE_FAST = 2'h3;

    // ------------------------------------------------------------
    // Timing: windows are counted in half-minute steps
    // ------------------------------------------------------------
    localparam longint SWT_CLK_HZ = 50_000_000;
    localparam longint SWT_STEP_S = 30;
    localparam longint SWT_STEP_CYCLES = SWT_CLK_HZ * SWT_STEP_S;
    localparam int SWT_STEP_CNT_W = 31;
    localparam int SWT_HALF_W = 5;
    localparam logic [SWT_HALF_W-1:0] SWT_FALLBACK_HALVES = 5'h0A;

    // Window select code to number of half-minute steps
    function automatic logic [SWT_HALF_W-1:0] swt_window_halves(input logic [3:0] sel);
        logic [SWT_HALF_W-1:0] h;
        h = SWT_FALLBACK_HALVES;
        unique case (sel)
            4'h0: h = 5'h04;
            4'h1: h = 5'h05;
            4'h2: h = 5'h06;
            4'h3: h = 5'h07;
            4'h4: h = 5'h08;
            4'h5: h = 5'h09;
            4'h6: h = 5'h0A;
            4'h7: h = 5'h0B;
            4'h8: h = 5'h0C;
            4'h9: h = 5'h0D;
            4'hA: h = 5'h10;
            4'hB: h = 5'h11;
            4'hC: h = 5'h14;
            4'hD: h = 5'h01;
            4'hE: h = SWT_FALLBACK_HALVES;
            4'hF: h = 5'h02;
        endcase
        return h;
    endfunction

endpackage

//--- include/swt_timer_if.sv
// Carrier between the register block and the window timer
interface swt_timer_if;
    import swt_pkg::*;
    logic start;
    logic stop;
    logic [SWT_HALF_W-1:0] halves;
    logic expire;
    logic running;

    modport ctrl (output start, output stop, output halves, input expire, input running);
    modport timer (input start, input stop, input halves, output expire, output running);
endinterface

//--- rtl/swt_window_timer.sv
// Inactivity window timer counting half-minute steps
module swt_window_timer
    import swt_pkg::*;
#(
    parameter longint STEP_CYCLES = SWT_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    swt_timer_if.timer tif
);

    localparam logic [SWT_STEP_CNT_W-1:0] STEP_LAST = SWT_STEP_CNT_W'(STEP_CYCLES - 1);

    logic run_r, run_nxt;
    logic expire_r, expire_nxt;
    logic [SWT_STEP_CNT_W-1:0] step_r, step_nxt;
    logic [SWT_HALF_W-1:0] left_r, left_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Stop outranks start so a host access in the wake cycle still counts
    always_comb begin
        run_nxt = run_r;
        step_nxt = step_r;
        left_nxt = left_r;
        expire_nxt = 1'b0;
        if (tif.stop) begin
            run_nxt = 1'b0;
        end else if (tif.start) begin
            run_nxt = 1'b1;
            step_nxt = '0;
            left_nxt = tif.halves;
        end else if (run_r) begin
            if (step_r == STEP_LAST) begin
                step_nxt = '0;
                if (left_r == 5'h01) begin
                    run_nxt = 1'b0;
                    expire_nxt = 1'b1;
                end else begin
                    left_nxt = left_r - 5'h01;
                end
            end else begin
                step_nxt = step_r + 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= 1'b0;
            expire_r <= 1'b0;
            step_r <= '0;
            left_r <= '0;
        end else begin
            run_r <= run_nxt;
            expire_r <= expire_nxt;
            step_r <= step_nxt;
            left_r <= left_nxt;
        end
    end

    assign tif.expire = expire_r;
    assign tif.running = run_r;

endmodule

//--- rtl/swt_top.sv
// Wake supervision timer and LIN transceiver control registers
module swt_top
    import swt_pkg::*;
#(
    parameter longint STEP_CYCLES = SWT_STEP_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic WAKE_EVENT,
    input wire logic LIN_MODE_HW_SET,
    input wire logic [1:0] LIN_MODE_HW_VAL,
    output logic SLEEP_REQ,
    output logic SUPERVISION_ACTIVE,
    output logic [1:0] LIN1_MODE,
    output logic LIN1_DTO_ENABLE
);

    logic sup_dis_r, sup_dis_nxt;
    logic [3:0] win_sel_r, win_sel_nxt;
    logic [1:0] lin_mode_r, lin_mode_nxt;
    logic dto_dis_r, dto_dis_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic sleep_r, sleep_nxt;
    logic active_r, active_nxt;
    logic dto_en_r, dto_en_nxt;
    logic host_access;
    logic wake_cfg_wr;
    logic lin_ctrl_wr;
    logic wake_cfg_rd;
    logic lin_ctrl_rd;

    swt_timer_if tif ();

    // ------------------------------------------------------------
    // Window timer
    // ------------------------------------------------------------
    swt_window_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .clk(CLK),
        .reset_n(RESET_N),
        .tif(tif)
    );

    // ------------------------------------------------------------
    // Register decode helpers
    // ------------------------------------------------------------
    // Address match, shared by the write and the read paths
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Read image of the wake supervision configuration; bits 2-0 read zero
    function automatic logic [7:0] wake_cfg_image(input logic dis, input logic [3:0] sel);
        logic [7:0] img;
        img = 8'h00;
        img[SWT_SUP_DIS_BIT] = dis;
        img[SWT_WIN_SEL_HI:SWT_WIN_SEL_LO] = sel;
        return img;
    endfunction

    // Read image of the LIN control register; bits 4-0 read zero
    function automatic logic [7:0] lin_ctrl_image(input logic [1:0] mode, input logic dto_dis);
        logic [7:0] img;
        img = 8'h00;
        img[SWT_LIN_MODE_HI:SWT_LIN_MODE_LO] = mode;
        img[SWT_DTO_DIS_BIT] = dto_dis;
        return img;
    endfunction

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    // Any register access counts as activity, mapped or not
    assign host_access = REG_WR | REG_RD;
    assign wake_cfg_wr = REG_WR & addr_hit(REG_ADDR, SWT_WAKE_CFG_ADDR);
    assign lin_ctrl_wr = REG_WR & addr_hit(REG_ADDR, SWT_LIN_CTRL_ADDR);
    assign wake_cfg_rd = REG_RD & addr_hit(REG_ADDR, SWT_WAKE_CFG_ADDR);
    assign lin_ctrl_rd = REG_RD & addr_hit(REG_ADDR, SWT_LIN_CTRL_ADDR);

    // Timer control
    always_comb begin
        tif.start = WAKE_EVENT & ~sup_dis_r;
        tif.stop = host_access | sup_dis_r;
        tif.halves = swt_window_halves(win_sel_r);
    end

    // ------------------------------------------------------------
    // Wake supervision configuration
    // ------------------------------------------------------------
    // Bits 2-0 of a write are dropped, so reserved bits never stick
    always_comb begin
        sup_dis_nxt = sup_dis_r;
        win_sel_nxt = win_sel_r;
        if (wake_cfg_wr) begin
            sup_dis_nxt = REG_WDATA[SWT_SUP_DIS_BIT];
            win_sel_nxt = REG_WDATA[SWT_WIN_SEL_HI:SWT_WIN_SEL_LO];
        end
    end

    // Power-up defaults
    // Only a reset restores them; no write path forces the defaults
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sup_dis_r <= SWT_SUP_DIS_RST;
            win_sel_r <= SWT_WIN_SEL_RST;
        end else begin
            sup_dis_r <= sup_dis_nxt;
            win_sel_r <= win_sel_nxt;
        end
    end

    // ------------------------------------------------------------
    // LIN transceiver control
    // ------------------------------------------------------------
    // Hardware mode update wins over a software write in the same cycle,
    // so a sleep entry from expiry is never masked by a late write.
    always_comb begin
        lin_mode_nxt = lin_mode_r;
        dto_dis_nxt = dto_dis_r;
        if (lin_ctrl_wr) begin
            lin_mode_nxt = REG_WDATA[SWT_LIN_MODE_HI:SWT_LIN_MODE_LO];
            dto_dis_nxt = REG_WDATA[SWT_DTO_DIS_BIT];
        end
        if (tif.expire) begin
            lin_mode_nxt = SWT_MODE_SLEEP;
        end else if (LIN_MODE_HW_SET) begin
            lin_mode_nxt = LIN_MODE_HW_VAL;
        end
    end

    // Standby with timeout protection on after reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lin_mode_r <= SWT_LIN_MODE_RST;
            dto_dis_r <= SWT_DTO_DIS_RST;
        end else begin
            lin_mode_r <= lin_mode_nxt;
            dto_dis_r <= dto_dis_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data holds until the next read; unmapped reads return zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (wake_cfg_rd) begin
            rdata_nxt = wake_cfg_image(sup_dis_r, win_sel_r);
        end else if (lin_ctrl_rd) begin
            rdata_nxt = lin_ctrl_image(lin_mode_r, dto_dis_r);
        end else if (REG_RD) begin
            rdata_nxt = 8'h00;
        end
    end

    // Read data register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // One cycle of latency on the sleep and active pins, traded for clean edges; the timeout enable adds none
    always_comb begin
        sleep_nxt = tif.expire;
        active_nxt = tif.running;
        dto_en_nxt = ~dto_dis_nxt;
    end

    // Outputs registered so pins never glitch
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sleep_r <= 1'b0;
            active_r <= 1'b0;
            dto_en_r <= ~SWT_DTO_DIS_RST;
        end else begin
            sleep_r <= sleep_nxt;
            active_r <= active_nxt;
            dto_en_r <= dto_en_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign SLEEP_REQ = sleep_r;
    assign SUPERVISION_ACTIVE = active_r;
    assign LIN1_MODE = lin_mode_r;
    assign LIN1_DTO_ENABLE = dto_en_r;

endmodule

//--- verification/swt_chk_sva.sv
// Port assertions for the wake supervision block
module swt_chk
    import swt_pkg::*;
#(
    parameter longint STEP_CYCLES = SWT_STEP_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic WAKE_EVENT,
    input wire logic LIN_MODE_HW_SET,
    input wire logic [1:0] LIN_MODE_HW_VAL,
    input wire logic SLEEP_REQ,
    input wire logic SUPERVISION_ACTIVE,
    input wire logic [1:0] LIN1_MODE,
    input wire logic LIN1_DTO_ENABLE
);
    logic dis_r;
    logic dis_nxt;
    logic lin_wr;
    // Shadow of the disable bit, since it is not on a port
    assign lin_wr = REG_WR && REG_ADDR == SWT_LIN_CTRL_ADDR;
    always_comb begin
        dis_nxt = dis_r;
        if (REG_WR && REG_ADDR == SWT_WAKE_CFG_ADDR) begin
            dis_nxt = REG_WDATA[SWT_SUP_DIS_BIT];
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dis_r <= SWT_SUP_DIS_RST;
        end else begin
            dis_r <= dis_nxt;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence wake_taken;
        WAKE_EVENT && !REG_WR && !REG_RD && !dis_r;
    endsequence
    sequence reg_access;
        REG_WR || REG_RD;
    endsequence
    // Two cycles without any access, so nothing stops a fresh start
    sequence host_quiet;
        (!REG_WR && !REG_RD) [*2];
    endsequence
    // Two cycles without a wake, so nothing restarts a stopped timer
    sequence wake_quiet;
        (!WAKE_EVENT) [*2];
    endsequence
    a_reset_values: assert property ($rose(RESET_N) |-> LIN1_MODE == 2'h0 && LIN1_DTO_ENABLE && !SLEEP_REQ)
        else $error("reset values");
    a_wake_starts: assert property (wake_taken ##1 host_quiet |=> SUPERVISION_ACTIVE)
        else $error("wake start");
    a_access_stops: assert property (reg_access ##1 wake_quiet |=> !SUPERVISION_ACTIVE)
        else $error("access stop");
    a_disable_blocks: assert property (dis_r && $past(dis_r) && $past(dis_r, 2) |-> !SUPERVISION_ACTIVE)
        else $error("disabled run");
    a_sleep_pulse: assert property (SLEEP_REQ |=> !SLEEP_REQ)
        else $error("sleep pulse");
    a_sleep_cause: assert property (SLEEP_REQ |-> $past(SUPERVISION_ACTIVE) && LIN1_MODE == SWT_MODE_SLEEP)
        else $error("sleep cause");
    a_timeout_follows: assert property (lin_wr |=> LIN1_DTO_ENABLE == !$past(REG_WDATA[5]))
        else $error("timeout bit");
    a_mode_write: assert property (lin_wr && !LIN_MODE_HW_SET |=> LIN1_MODE == $past(REG_WDATA[7:6]) || SLEEP_REQ)
        else $error("mode write");
endmodule
bind swt_top swt_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .WAKE_EVENT(WAKE_EVENT),
    .LIN_MODE_HW_SET(LIN_MODE_HW_SET), .LIN_MODE_HW_VAL(LIN_MODE_HW_VAL), .SLEEP_REQ(SLEEP_REQ),
    .SUPERVISION_ACTIVE(SUPERVISION_ACTIVE), .LIN1_MODE(LIN1_MODE), .LIN1_DTO_ENABLE(LIN1_DTO_ENABLE));

//--- verification/swt_host.sv
// Host model issuing register reads and writes
module swt_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines start low
    initial begin
        {addr, wdata, wr, rd} = '0;
    end
    // one access per call
    // Released address and data lines invert and strobes drop, so stale values never pass as valid
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        {addr, wdata, wr, rd} = {a, d, w, !w};
        @(posedge clk);
        #1;
        q = rdata;
        {addr, wdata, wr, rd} = {~a, ~d, 2'b00};
    endtask
endmodule

//--- verification/swt_top_bench.sv
// Self-checking bench for the wake supervision block
module swt_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import swt_pkg::*;
    localparam longint STEP = 4;
    logic clk, reset_n, wr, rd, wake, hw_set, sleep_req, active, dto_en;
    logic [1:0] hw_val, lin_mode;
    logic [7:0] addr, wdata, rdata, q, d;
    int num_errors = 0;
    int compares = 0;
    int n;
    swt_top #(.STEP_CYCLES(STEP)) dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .WAKE_EVENT(wake), .LIN_MODE_HW_SET(hw_set),
        .LIN_MODE_HW_VAL(hw_val), .SLEEP_REQ(sleep_req), .SUPERVISION_ACTIVE(active), .LIN1_MODE(lin_mode),
        .LIN1_DTO_ENABLE(dto_en));
    swt_host host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run needs about 1200 cycles
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    function automatic int halves(input logic [3:0] c);
        case (c)
            4'hA: return 16;
            4'hB: return 17;
            4'hC: return 20;
            4'hD: return 1;
            4'hE: return 10;
            4'hF: return 2;
            default: return int'(c) + 4;
        endcase
    endfunction
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pulse_wake();
        @(posedge clk);
        #1;
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
    endtask
    // Gives up after 200 cycles, which then reads as no sleep
    task automatic wait_sleep(output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (sleep_req !== 1'b1 && k < 200);
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {wake, hw_set, hw_val} = '0;
        void'($urandom(32'hb443da60));
        do_reset();
        chk("tmo", {7'h00, dto_en}, 8'h01);
        host.access(1'b0, SWT_WAKE_CFG_ADDR, 8'h00, q);
        chk("cfg", q, 8'h30);
        host.access(1'b0, 8'h55, 8'h00, q);
        chk("unmapped", q, 8'h00);
        for (int i = 0; i < 10; i++) begin
            d = (i < 2) ? {8{i[0]}} : 8'($urandom);
            host.access(1'b1, SWT_LIN_CTRL_ADDR, d, q);
            host.access(1'b0, SWT_LIN_CTRL_ADDR, 8'h00, q);
            chk("lin", q, d & 8'hE0);
            chk("mode", {6'h00, lin_mode}, {6'h00, d[7:6]});
            chk("tmo", {7'h00, dto_en}, {7'h00, ~d[5]});
        end
        // Hardware mode updates, every code
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            #1;
            {hw_set, hw_val} = {1'b1, 2'(m)};
            @(posedge clk);
            #1;
            hw_set = 1'b0;
            host.access(1'b0, SWT_LIN_CTRL_ADDR, 8'h00, q);
            chk("hw mode", q, {2'(m), d[5], 5'h00});
        end
        for (int c = 0; c < 16; c++) begin
            d = {1'b0, c[3:0], 3'($urandom)};
            host.access(1'b1, SWT_WAKE_CFG_ADDR, d, q);
            host.access(1'b0, SWT_WAKE_CFG_ADDR, 8'h00, q);
            chk("win", q, d & 8'hF8);
            pulse_wake();
            wait_sleep(n);
            chk("delay", 8'(n), 8'(halves(c[3:0]) * STEP + 1));
            chk("slp", {6'h00, lin_mode}, {6'h00, SWT_MODE_SLEEP});
        end
        // A mid-window access ends supervision
        host.access(1'b1, SWT_WAKE_CFG_ADDR, 8'h30, q);
        pulse_wake();
        repeat (20) @(posedge clk);
        #1;
        chk("kept run", {7'h00, active}, 8'h01);
        host.access(1'b0, 8'h40, 8'h00, q);
        wait_sleep(n);
        chk("kept", 8'(n), 8'hC8);
        chk("kept stop", {7'h00, active}, 8'h00);
        host.access(1'b1, SWT_WAKE_CFG_ADDR, 8'hB0, q);
        pulse_wake();
        wait_sleep(n);
        chk("dis", 8'(n), 8'hC8);
        chk("dis run", {7'h00, active}, 8'h00);
        do_reset();
        host.access(1'b0, SWT_WAKE_CFG_ADDR, 8'h00, q);
        chk("cfg", q, 8'h30);
        test_done();
    end
endmodule
